// ===== design/axss_top.sv
/*
  Axis safety supervisor: limits, home, TTL I/O, watchdog relay,
  following-error checking and a proportional servo loop.
  Assumes AHB-Lite master, synchronous field inputs, one clock.
*/
`default_nettype none
module axss_top
  import axss_pkg::*;
#(
  parameter longint unsigned INIT_CNT = INIT_CYCLES,
  parameter int unsigned     WDOG_CNT = WDOG_CYCLES,
  parameter int unsigned     SERVO_CNT = SERVO_CYCLES
)(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Field inputs
  input  wire logic [7:0]            limit_in,
  input  wire logic [3:0]            home_in,
  input  wire logic [NUM_DIN-1:0]    din,
  input  wire logic [NUM_AXES*POS_W-1:0] enc_pos,
  input  wire logic [NUM_ADC*ADC_W-1:0]  adc_data,
  input  wire logic                  adc_fitted,
  // Field outputs
  output logic [NUM_DOUT-1:0]        dout,
  output logic [NUM_AXES-1:0]        amp_enable_n,
  output logic [NUM_AXES*CMD_W-1:0]  cmd_out,
  output logic                       wdog_relay
);
  // ************************************************************
  // Bus address phase capture
  // ************************************************************
  axss_req_s req_ff, nxt_req;
  always_comb
  begin
    nxt_req = '{htrans: htrans, hwrite: hwrite, haddr: haddr, hsel: hsel && hready};
    if (!(hsel && hready))
    begin
      nxt_req.htrans = 2'h0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req_ff <= '0;
    else
      req_ff <= nxt_req;
  end
  logic wr_en;
  logic rd_en;
  assign wr_en = req_ff.hsel && req_ff.htrans[1] && req_ff.hwrite;
  assign rd_en = req_ff.hsel && req_ff.htrans[1] && !req_ff.hwrite;

  // ************************************************************
  // Control registers
  // ************************************************************
  logic                  started_ff, nxt_started;
  logic [NUM_AXES-1:0]   axen_ff, nxt_axen;
  logic [11:0]           inpol_ff, nxt_inpol;
  logic [NUM_DOUT-1:0]   outpol_ff, nxt_outpol;
  logic [NUM_DOUT-1:0]   dreg_ff, nxt_dreg;
  logic [15:0]           mode_ff, nxt_mode;
  logic [2:0]            sel_ff, nxt_sel;
  logic [3:0]            gain_ff, nxt_gain;
  logic [NUM_AXES*POS_W-1:0] maxerr_ff, nxt_maxerr;
  logic [NUM_AXES*POS_W-1:0] target_ff, nxt_target;
  logic [NUM_AXES-1:0]   ferr_ff, nxt_ferr;
  logic [NUM_AXES-1:0]   stop_ff, nxt_stop;
  logic [NUM_AXES-1:0]   ferr_trip;
  logic [NUM_AXES-1:0]   stop_trip;
  logic                  kick;
  logic                  init_done_ff;
  logic                  servo_tick;
  logic [NUM_AXES*CMD_W-1:0] nxt_cmd;
  always_comb
  begin
    nxt_started = started_ff;
    nxt_axen = axen_ff;
    nxt_inpol = inpol_ff;
    nxt_outpol = outpol_ff;
    nxt_dreg = dreg_ff;
    nxt_mode = mode_ff;
    nxt_sel = sel_ff;
    nxt_gain = gain_ff;
    nxt_maxerr = maxerr_ff;
    nxt_target = target_ff;
    kick = 1'b0;
    if (wr_en)
    begin
      unique case (req_ff.haddr)
        REG_CTRL:
        begin
          nxt_started = started_ff | hwdata[0];
          kick = hwdata[1];
        end
        REG_ENABLE: nxt_axen = axen_ff | hwdata[7:0];
        REG_DISABLE: nxt_axen = axen_ff & ~hwdata[7:0];
        REG_INPOL: nxt_inpol = hwdata[11:0]; // RULE6
        REG_OUTPOL: nxt_outpol = hwdata[15:0]; // RULE9
        REG_DOUT: nxt_dreg = hwdata[15:0];
        REG_MODE: nxt_mode = hwdata[15:0];
        REG_SEL: nxt_sel = hwdata[2:0];
        REG_GAIN: nxt_gain = hwdata[3:0];
        REG_MAXERR: nxt_maxerr[sel_ff*POS_W +: POS_W] = hwdata[POS_W-1:0];
        REG_TARGET: nxt_target[sel_ff*POS_W +: POS_W] = hwdata[POS_W-1:0];
        default: ;
      endcase
    end
    // Following-error trips drop the enable; a trip wins over a same-cycle enable write
    nxt_axen = nxt_axen & ~ferr_trip; // RULE13
  end
  // Following-error and stop flags: set wins, axis enable call clears
  always_comb
  begin
    nxt_ferr = ferr_ff;
    nxt_stop = stop_ff;
    if (wr_en && req_ff.haddr == REG_ENABLE)
    begin
      nxt_ferr = ferr_ff & ~hwdata[7:0]; // RULE14
      nxt_stop = stop_ff & ~hwdata[7:0];
    end
    nxt_ferr = nxt_ferr | ferr_trip;
    nxt_stop = nxt_stop | stop_trip;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      started_ff <= 1'b0;
      axen_ff <= '0; // RULE19
      inpol_ff <= '0;
      outpol_ff <= '0; // RULE9
      dreg_ff <= '0;
      mode_ff <= '0;
      sel_ff <= '0;
      gain_ff <= GAIN_RST;
      maxerr_ff <= {NUM_AXES{MAXERR_RST}};
      target_ff <= '0;
      ferr_ff <= '0;
      stop_ff <= '0;
    end
    else
    begin
      started_ff <= nxt_started;
      axen_ff <= nxt_axen;
      inpol_ff <= nxt_inpol;
      outpol_ff <= nxt_outpol;
      dreg_ff <= nxt_dreg;
      mode_ff <= nxt_mode;
      sel_ff <= nxt_sel;
      gain_ff <= nxt_gain;
      maxerr_ff <= nxt_maxerr;
      target_ff <= nxt_target;
      ferr_ff <= nxt_ferr;
      stop_ff <= nxt_stop;
    end
  end

  // ************************************************************
  // Initialization timer and watchdog
  // ************************************************************
  logic [38:0] init_cnt_ff, nxt_init_cnt;
  logic        nxt_init_done;
  logic [31:0] wd_cnt_ff, nxt_wd_cnt;
  logic        trip_ff, nxt_trip;
  logic        nxt_relay;
  always_comb
  begin
    nxt_init_cnt = init_cnt_ff;
    nxt_init_done = init_done_ff;
    if (!init_done_ff)
    begin
      if (init_cnt_ff == 39'(INIT_CNT - 1))
        nxt_init_done = 1'b1; // RULE8
      else
        nxt_init_cnt = init_cnt_ff + 39'h1;
    end
    nxt_wd_cnt = wd_cnt_ff;
    nxt_trip = trip_ff;
    if (init_done_ff && !trip_ff)
    begin
      if (kick)
        nxt_wd_cnt = '0;
      else if (wd_cnt_ff == WDOG_CNT - 1)
        nxt_trip = 1'b1; // RULE20
      else
        nxt_wd_cnt = wd_cnt_ff + 32'h1;
    end
    nxt_relay = init_done_ff && !nxt_trip; // RULE12 RULE20
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_cnt_ff <= '0;
      init_done_ff <= 1'b0;
      wd_cnt_ff <= '0;
      trip_ff <= 1'b0;
      wdog_relay <= 1'b0;
    end
    else
    begin
      init_cnt_ff <= nxt_init_cnt;
      init_done_ff <= nxt_init_done;
      wd_cnt_ff <= nxt_wd_cnt;
      trip_ff <= nxt_trip;
      wdog_relay <= nxt_relay;
    end
  end

  // ************************************************************
  // Limit, home sensing and digital outputs
  // ************************************************************
  logic [7:0]          lim_act;
  logic [3:0]          home_act;
  logic [NUM_DOUT-1:0] nxt_dout;
  logic [NUM_AXES-1:0] moving_pos;
  logic [NUM_AXES-1:0] moving_neg;
  // Active-low sensing inverts, so an open wire reads as active
  assign lim_act = limit_in ^ inpol_ff[7:0]; // RULE6
  assign home_act = home_in ^ inpol_ff[11:8]; // RULE5 RULE6
  always_comb
  begin
    stop_trip = '0;
    for (int a = 0; a < NUM_AXES; a++)
    begin
      // Limit pair p: bit 2p is plus, 2p+1 minus; axis a and a+4 share it
      logic lp;
      logic ln;
      lp = lim_act[2*(a%NUM_PAIRS)]; // RULE1
      ln = lim_act[2*(a%NUM_PAIRS)+1];
      unique case (axss_mode_e'(mode_ff[2*a +: 2]))
        MODE_POSITION, MODE_VELOCITY:
          stop_trip[a] = (lp && moving_pos[a]) || (ln && moving_neg[a]); // RULE2
        MODE_CONTOUR: stop_trip[a] = lp || ln; // RULE3
        MODE_TORQUE: stop_trip[a] = 1'b0; // RULE4
      endcase
      stop_trip[a] = stop_trip[a] && axen_ff[a];
    end
    // High until init done, then low; sinking outputs held active-low
    if (!init_done_ff)
      nxt_dout = '1; // RULE8
    else if (!started_ff)
      nxt_dout = '0; // RULE10
    else
      nxt_dout = dreg_ff ^ outpol_ff; // RULE9
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout <= '1;
    else
      dout <= nxt_dout;
  end

  // ************************************************************
  // Servo tick and per-axis loop
  // ************************************************************
  logic [15:0] tick_cnt_ff, nxt_tick_cnt;
  logic [NUM_AXES*POS_W-1:0] err_ff, nxt_err;
  always_comb
  begin
    nxt_tick_cnt = (tick_cnt_ff == 16'(SERVO_CNT - 1)) ? 16'h0 : tick_cnt_ff + 16'h1;
    servo_tick = (tick_cnt_ff == 16'(SERVO_CNT - 1)); // RULE18
    nxt_err = err_ff;
    nxt_cmd = cmd_out;
    ferr_trip = '0;
    for (int a = 0; a < NUM_AXES; a++)
    begin
      logic signed [POS_W-1:0] e;
      logic [POS_W-1:0] mag;
      e = $signed(target_ff[a*POS_W +: POS_W] - enc_pos[a*POS_W +: POS_W]);
      mag = e[POS_W-1] ? POS_W'(-e) : POS_W'(e);
      moving_pos[a] = !err_ff[a*POS_W+POS_W-1] && (err_ff[a*POS_W +: POS_W] != '0);
      moving_neg[a] = err_ff[a*POS_W+POS_W-1];
      if (servo_tick)
      begin
        nxt_err[a*POS_W +: POS_W] = e; // RULE18
        // Zero limit disables the check
        ferr_trip[a] = axen_ff[a] && (maxerr_ff[a*POS_W +: POS_W] != '0)
                       && (mag > maxerr_ff[a*POS_W +: POS_W]); // RULE13 RULE15
      end
      if (!nxt_axen[a] || stop_ff[a] || ferr_ff[a] || ferr_trip[a])
        nxt_cmd[a*CMD_W +: CMD_W] = '0; // RULE13
      else if (servo_tick)
        nxt_cmd[a*CMD_W +: CMD_W] = CMD_W'(e <<< gain_ff); // RULE17
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_ff <= '0;
      err_ff <= '0;
      cmd_out <= '0;
      amp_enable_n <= '1; // RULE19
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      err_ff <= nxt_err;
      cmd_out <= nxt_cmd;
      amp_enable_n <= ~nxt_axen; // RULE13 RULE19
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = '0;
    if (nxt_req.hsel && nxt_req.htrans[1] && !nxt_req.hwrite)
    begin
      unique case (nxt_req.haddr)
        REG_CTRL: nxt_rdata = {31'h0, started_ff};
        REG_STATUS: nxt_rdata = {29'h0, trip_ff, wdog_relay, init_done_ff};
        REG_ENABLE: nxt_rdata = {24'h0, axen_ff};
        REG_FERR: nxt_rdata = {24'h0, ferr_ff};
        REG_STOP: nxt_rdata = {24'h0, stop_ff};
        REG_INPOL: nxt_rdata = {20'h0, inpol_ff};
        REG_OUTPOL: nxt_rdata = {16'h0, outpol_ff};
        REG_DOUT: nxt_rdata = {16'h0, dreg_ff};
        REG_DIN: nxt_rdata = {4'h0, home_act, lim_act, din}; // RULE7
        REG_MODE: nxt_rdata = {16'h0, mode_ff};
        REG_SEL: nxt_rdata = {29'h0, sel_ff};
        REG_MAXERR: nxt_rdata = {8'h0, maxerr_ff[sel_ff*POS_W +: POS_W]};
        REG_TARGET: nxt_rdata = {8'h0, err_ff[sel_ff*POS_W +: POS_W]};
        REG_ADC: nxt_rdata = adc_fitted ? {18'h0, adc_data[sel_ff*ADC_W +: ADC_W]} : 32'h0; // RULE11
        REG_GAIN: nxt_rdata = {28'h0, gain_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hrdata <= nxt_rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_ferr_trip;
    servo_tick && (ferr_trip != '0);
  endsequence
  a_ferr_disable: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ferr_trip |=> ((amp_enable_n & $past(ferr_trip)) == $past(ferr_trip)))
    else $error("amp enable not dropped on following error"); // RULE13
  a_ferr_cmd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ferr_ff[0] |-> cmd_out[CMD_W-1:0] == '0)
    else $error("command not zero while following error"); // RULE13
  a_ferr_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    ferr_ff[0] && !(wr_en && req_ff.haddr == REG_ENABLE) |=> ferr_ff[0])
    else $error("following error cleared without enable"); // RULE14
  a_zero_nocheck: assert property (@(posedge hclk) disable iff (!hresetn)
    maxerr_ff[POS_W-1:0] == '0 |-> !ferr_trip[0])
    else $error("check with zero allowable error"); // RULE15
  a_dout_init: assert property (@(posedge hclk) disable iff (!hresetn)
    !init_done_ff |=> dout == '1)
    else $error("outputs not high during init"); // RULE8
  a_dout_sink_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(init_done_ff) && !started_ff && !$past(started_ff) |-> dout == '0)
    else $error("outputs not low before host start"); // RULE10
  a_relay_init: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(init_done_ff) && !trip_ff |=> wdog_relay)
    else $error("relay not energized after init"); // RULE12
  a_relay_trip: assert property (@(posedge hclk) disable iff (!hresetn)
    trip_ff |-> ##1 !wdog_relay [*3])
    else $error("relay closed after watchdog trip"); // RULE20
  a_torque_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_ff[1:0] == 2'h3 |-> !stop_trip[0])
    else $error("torque mode stopped on limit"); // RULE4
  a_contour_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_ff[1:0] == 2'h2 && axen_ff[0] && lim_act[0] |=> stop_ff[0])
    else $error("contour mode ignored limit"); // RULE3
  a_amp_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    axen_ff == '0 && !(wr_en && req_ff.haddr == REG_ENABLE) |=> amp_enable_n == '1)
    else $error("amp enable active before enable call"); // RULE19
  a_servo_period: assert property (@(posedge hclk) disable iff (!hresetn)
    servo_tick |=> !servo_tick [*8])
    else $error("servo tick too frequent"); // RULE18
endmodule
`default_nettype wire

// ===== design/axss_pkg.sv
/*
  Constants, types and register map of the axis safety supervisor.
  Assumes one 100 MHz clock and an AHB-Lite bus with one slave.
*/
// Notes on behaviour
// [RULE1] Eight limit inputs, each shared by axis n and axis n+4.
// [RULE2] Position and velocity modes stop only when moving toward that limit.
// [RULE3] Contour mode stops on any active limit regardless of direction.
// [RULE4] Torque mode ignores limit inputs.
// [RULE5] Four coarse-home inputs, each shared by axis n and axis n+4.
// [RULE6] Active-low sensing reports an opened switch or broken wire as active.
// [RULE7] Four TTL digital inputs per connector group, readable by software.
// [RULE8] Outputs high from reset until initialization completes, then low.
// [RULE9] Outputs default sourcing; each can be set to sinking polarity.
// [RULE10] Sinking outputs stay active-low until host software has started.
// [RULE11] Two 14-bit A/D channels per group, eight in all, when fitted.
// [RULE12] After reset and initialization, watchdog enabled and relay energized.
// [RULE13] Following error over limit drops enable, zeroes command, flags status.
// [RULE14] Following-error condition holds until the host re-enables the axis.
// [RULE15] Allowable following error of zero disables checking for that axis.
// [RULE16] Host sets velocity, acceleration and deceleration before any motion; the design has no such registers, only a target.
// [RULE17] Servo turned on with position error drives a correcting command.
// [RULE18] Servo filter evaluated every 250 us, forming following error.
// [RULE19] Amplifier enable stays inactive high until the host enables the axis.
// [RULE20] Watchdog timeout opens the relay until next reset and initialization.
`default_nettype none
package axss_pkg;
  localparam int unsigned NUM_AXES = 8;
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned NUM_DIN = 16;
  localparam int unsigned NUM_DOUT = 16;
  localparam int unsigned NUM_ADC = 8;
  localparam int unsigned ADC_W = 14;
  localparam int unsigned POS_W = 24;
  localparam int unsigned CMD_W = 16;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SERVO_PERIOD_US = 250;
  localparam int unsigned SERVO_CYCLES = SERVO_PERIOD_US * CLK_MHZ;
  localparam int unsigned INIT_MIN_S = 30;
  localparam longint unsigned INIT_CYCLES = longint'(INIT_MIN_S) * 1000000 * CLK_MHZ;
  localparam int unsigned WDOG_TIMEOUT_US = 100000;
  localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_US * CLK_MHZ;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;   // [0] host started, [1] watchdog kick
  localparam logic [7:0] REG_STATUS = 8'h04; // [0] init done, [1] relay, [2] wdog trip
  localparam logic [7:0] REG_ENABLE = 8'h08; // Write 1 = axis enable call
  localparam logic [7:0] REG_DISABLE = 8'h0C;
  localparam logic [7:0] REG_FERR = 8'h10;   // Following-error flags
  localparam logic [7:0] REG_STOP = 8'h14;   // Limit stop flags
  localparam logic [7:0] REG_INPOL = 8'h18;  // [7:0] limit, [11:8] home active-low
  localparam logic [7:0] REG_OUTPOL = 8'h1C; // Active-low polarity select per output
  localparam logic [7:0] REG_DOUT = 8'h20;
  localparam logic [7:0] REG_DIN = 8'h24;    // [15:0] din, [23:16] limits, [27:24] home
  localparam logic [7:0] REG_MODE = 8'h28;   // 2 bits per axis
  localparam logic [7:0] REG_SEL = 8'h2C;    // Axis index for windowed access
  localparam logic [7:0] REG_MAXERR = 8'h30; // Allowable error of selected axis
  localparam logic [7:0] REG_TARGET = 8'h34; // Write desired position, read following error of selected axis
  localparam logic [7:0] REG_ADC = 8'h38;    // Sample of selected A/D channel
  localparam logic [7:0] REG_GAIN = 8'h3C;   // Proportional gain shift, all axes
  localparam logic [POS_W-1:0] MAXERR_RST = 24'h000000;
  localparam logic [3:0] GAIN_RST = 4'h0;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {MODE_POSITION, MODE_VELOCITY, MODE_CONTOUR, MODE_TORQUE} axss_mode_e;
  typedef struct packed {
    logic [1:0]       htrans;
    logic             hwrite;
    logic [7:0]       haddr;
    logic             hsel;
  } axss_req_s;
  typedef logic [POS_W-1:0] axss_pos_t;
endpackage
`default_nettype wire

// ===== verif/axss_field.sv
/*
  Field-side model: limit and home sensors, TTL inputs, encoders and A/D.
  Assumes the bench sets the levels through its tasks just after a clock edge.
*/
`default_nettype none
module axss_field
  import axss_pkg::*;
(
  // Sensor and feedback lines
  output logic [7:0]                 limit_in,
  output logic [3:0]                 home_in,
  output logic [NUM_DIN-1:0]         din,
  output logic [NUM_AXES*POS_W-1:0]  enc_pos,
  output logic [NUM_ADC*ADC_W-1:0]   adc_data,
  output logic                       adc_fitted
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle field: switches open, encoders at zero, no A/D option
  initial
  begin
    limit_in = 8'h00;
    home_in = 4'h0;
    din = 16'h0000;
    enc_pos = '0;
    adc_data = '0;
    adc_fitted = 1'b0;
  end
  // Sensor levels; an opened closed-contact switch or cut wire reads low
  task automatic set_io(input logic [7:0] lim, input logic [3:0] hom, input logic [15:0] d);
    limit_in <= lim;
    home_in <= hom;
    din <= d;
  endtask
  // Encoder count of one axis
  task automatic set_enc(input int ax, input logic [POS_W-1:0] p);
    enc_pos[ax*POS_W +: POS_W] <= p;
  endtask
  // A/D option presence and one channel sample
  task automatic set_adc(input logic f, input int ch, input logic [ADC_W-1:0] v);
    adc_fitted <= f;
    adc_data[ch*ADC_W +: ADC_W] <= v;
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/*
  Self-checking bench: AHB-Lite register access, field model, timed checks.
  Assumes zero-wait slave and shortened init, watchdog and servo counts.
*/
`default_nettype none
module testbench
  import axss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]                haddr;
  logic [1:0]                htrans;
  logic [2:0]                hsize;
  logic [31:0]               hwdata, hrdata, q;
  logic [7:0]                limit_in, amp_enable_n;
  logic [3:0]                home_in;
  logic [15:0]               din, dout;
  logic [NUM_AXES*POS_W-1:0] enc_pos;
  logic [NUM_ADC*ADC_W-1:0]  adc_data;
  logic [NUM_AXES*CMD_W-1:0] cmd_out;
  logic                      adc_fitted, wdog_relay, stp;
  int                        err_count, cmp_count, cyc;
  axss_top #(.INIT_CNT(20), .WDOG_CNT(200), .SERVO_CNT(50)) axss_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .limit_in(limit_in), .home_in(home_in),
    .din(din), .enc_pos(enc_pos), .adc_data(adc_data), .adc_fitted(adc_fitted),
    .dout(dout), .amp_enable_n(amp_enable_n), .cmd_out(cmd_out), .wdog_relay(wdog_relay));
  axss_field axss_field_i (
    .limit_in(limit_in), .home_in(home_in), .din(din), .enc_pos(enc_pos),
    .adc_data(adc_data), .adc_fitted(adc_fitted));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single AHB transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask
  // Clock and hang guard
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    wt(2);
    chk({dout, amp_enable_n, 7'h00, wdog_relay}, 32'hFFFF_FF00);
    chk({31'h0, |cmd_out}, 32'h0);
    hresetn <= 1'b1;
    wt(8);
    chk({16'h0, dout}, 32'h0000FFFF);
    wt(20);
    chk({15'h0, dout, wdog_relay}, 32'h1);
    // Kick holds the relay, silence opens it for good
    wt(150);
    wr(REG_CTRL, 32'h2);
    wt(100);
    chk({31'h0, wdog_relay}, 32'h1);
    wt(210);
    chk({31'h0, wdog_relay}, 32'h0);
    rdc(REG_STATUS, 32'h5);
    rdc(REG_GAIN, 32'h0);
    rdc(REG_MAXERR, 32'h0);
    rdc(8'h40, 32'h0);
    // Sinking output held low until host start, then polarity applies
    wr(REG_OUTPOL, 32'h1);
    wr(REG_DOUT, 32'hF0);
    wt(2);
    chk({16'h0, dout}, 32'h0);
    wr(REG_CTRL, 32'h1);
    wt(2);
    chk({16'h0, dout}, 32'hF1);
    // Inputs with one limit and one home sensed active-low
    axss_field_i.set_io(8'hFE, 4'h9, 16'hA5C3);
    wr(REG_INPOL, 32'h101);
    wt(2);
    rdc(REG_DIN, 32'h08FFA5C3);
    wr(REG_INPOL, 32'h0);
    axss_field_i.set_io(8'h00, 4'h0, 16'h0000);
    axss_field_i.set_adc(1'b1, 3, 14'h2ABC);
    wr(REG_SEL, 32'h3);
    rdc(REG_ADC, 32'h2ABC);
    axss_field_i.set_adc(1'b0, 3, 14'h2ABC);
    wt(2);
    rdc(REG_ADC, 32'h0);
    // Following error on axis 0
    wr(REG_SEL, 32'h0);
    // Motion parameters are set before the axis is enabled
    wr(REG_TARGET, 32'd100);
    wr(REG_ENABLE, 32'h1);
    wt(2);
    chk({31'h0, amp_enable_n[0]}, 32'h0);
    wt(120);
    rdc(REG_FERR, 32'h0);
    chk({31'h0, ($signed(cmd_out[15:0]) > 16'sh0000)}, 32'h1);
    wr(REG_MAXERR, 32'd10);
    wt(120);
    rdc(REG_FERR, 32'h1);
    chk({15'h0, amp_enable_n[0], cmd_out[15:0]}, 32'h10000);
    wt(120);
    rdc(REG_FERR, 32'h1);
    axss_field_i.set_enc(0, 24'd100);
    wt(2);
    wr(REG_ENABLE, 32'h1);
    wt(120);
    rdc(REG_FERR, 32'h0);
    // Limit response for every mode and both limit sides, moving plus
    wr(REG_MAXERR, 32'h0);
    axss_field_i.set_enc(0, 24'd0);
    for (int i = 0; i < 8; i++)
    begin
      stp = (i / 2 == 2) || (i / 2 < 2 && i % 2 == 1);
      axss_field_i.set_io(8'h00, 4'h0, 16'h0000);
      wr(REG_MODE, i / 2);
      wr(REG_ENABLE, 32'h1);
      wt(60);
      axss_field_i.set_io((i % 2 == 1) ? 8'h01 : 8'h02, 4'h0, 16'h0000);
      wt(110);
      rdc(REG_STOP, {31'h0, stp});
    end
    // Disable call drops the amplifier enable and zeroes the command
    wr(REG_DISABLE, 32'h1);
    wt(2);
    chk({15'h0, amp_enable_n[0], cmd_out[15:0]}, 32'h10000);
    rdc(REG_ENABLE, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // Second reset in mid-run
    hresetn <= 1'b0;
    wt(2);
    chk({dout, amp_enable_n, 7'h00, wdog_relay}, 32'hFFFF_FF00);
    hresetn <= 1'b1;
    wt(28);
    chk({dout, amp_enable_n, 7'h00, wdog_relay}, 32'h0000_FF01);
    stop_test();
  end
endmodule
`default_nettype wire
